// ==== core/ctsw_regs.vh ====
`ifndef CTSW_REGS_VH
`define CTSW_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CTSW_ADDR_MODE 4'h0
`define CTSW_ADDR_PORT 4'h1
`define CTSW_ADDR_COUNT 4'h2
`define CTSW_ADDR_CAPR 4'h3
`define CTSW_ADDR_CAPF 4'h4
`define CTSW_ADDR_STAT 4'h5
`define CTSW_ADDR_MASK 4'h6
// ----------------------------------------
// mode register fields
// ----------------------------------------
`define CTSW_MODE_CKS_LO 0
`define CTSW_MODE_CKS_HI 1
`define CTSW_MODE_CCLR_LO 2
`define CTSW_MODE_CCLR_HI 3
`define CTSW_MODE_IEDGE 4
`define CTSW_MODE_OVIE 5
`define CTSW_MODE_OVFL 6
`define CTSW_MODE_OVFH 7
// ----------------------------------------
// port mode fields
// ----------------------------------------
`define CTSW_PORT_FUNC 0
`define CTSW_PORT_NCS 1
// ----------------------------------------
// status fields
// ----------------------------------------
`define CTSW_ST_REQ 0
`define CTSW_ST_CAPR 1
`define CTSW_ST_CAPF 2
`define CTSW_ST_OVF 3
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define CTSW_RST_BYTE 8'h00
`define CTSW_RST_NIB 4'h0
`define CTSW_DIV_64 6'h3F
`define CTSW_DIV_32 6'h1F
`define CTSW_DIV_2 6'h01
`define CTSW_WDIV_4 2'h3
`define CTSW_FILT_TAPS 5
`endif

// ==== core/ctsw_filter.v ====
`timescale 1ns/1ps
`include "ctsw_regs.vh"
module ctsw_filter #(
    parameter TAPS = `CTSW_FILT_TAPS
) (
    input wire ref_clk,
    input wire rst_n,
    input wire sample,
    input wire din,
    output reg dout
);
    reg [TAPS-1:0] taps;
    // ----------------------------------------
    // five latch shift and match
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            taps <= {TAPS{1'b0}};
            dout <= 1'b0;
        end else if (sample) begin
            taps <= {taps[TAPS-2:0], din};
            if (&taps)
                dout <= 1'b1;
            else if (~|taps)
                dout <= 1'b0;
        end
    end
endmodule

// ==== core/ctsw_core.v ====
`timescale 1ns/1ps
`include "ctsw_regs.vh"
// Contract
// - counter steps once per falling edge of selected prescaled clock
// - clock switch from high source to low source counts one step
// - function bit set while pin high gives rising internal edge
// - function bit cleared while pin high gives falling internal edge
// - filter on, function set early: edge follows pin level
// - filter on pin high, function cleared late: falling edge
// - internal capture signal low when pin function off
// - pin rises, filter enabled early: rising edge
// - pin falls, filter disabled early: falling edge
// - spurious edge sets request when it matches selected edge
// - filter passes level only when five samples agree
// - four clock sources from system or watch clock, also filter clock
module ctsw_core (
    input wire ref_clk,
    input wire rst_b,
    input wire watch_clk_in,
    input wire capture_pin,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    output reg capture_in_level,
    output reg irq
);
    reg rst_s1, rst_s2;
    wire rst_n = rst_s2;
    reg [7:0] timer_mode_register, capture_counter, cap_rise, cap_fall;
    reg capture_pin_function, noise_filter_enable;
    reg [3:0] stat, mask;
    reg [5:0] div;
    reg [1:0] wdiv;
    reg w_s1, w_s2, w_d;
    reg clk_sel_d;
    reg cap_d;
    wire [1:0] cks = {timer_mode_register[`CTSW_MODE_CKS_HI],
                      timer_mode_register[`CTSW_MODE_CKS_LO]};
    wire filt_out;
    wire w_rise = w_s2 & ~w_d;
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    // ----------------------------------------
    // prescalers
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 6'h00;
            wdiv <= 2'h0;
            w_s1 <= 1'b0;
            w_s2 <= 1'b0;
            w_d <= 1'b0;
        end else begin
            div <= div + 6'h01;
            w_s1 <= watch_clk_in;
            w_s2 <= w_s1;
            w_d <= w_s2;
            if (w_rise)
                wdiv <= wdiv + 2'h1;
        end
    end
    // selected clock level; a write changes it instantly
    reg next_clk_sel;
    always @* begin
        case (cks)
            2'h0: next_clk_sel = div[5];
            2'h1: next_clk_sel = div[4];
            2'h2: next_clk_sel = div[0];
            default: next_clk_sel = wdiv[1];
        endcase
    end
    // falling edge of selected level, whether from the clock or a switch
    wire count_tick = clk_sel_d & ~next_clk_sel;
    wire samp_tick = noise_filter_enable ? (~clk_sel_d & next_clk_sel) : 1'b1;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sel_d <= 1'b0;
        end else begin
            clk_sel_d <= next_clk_sel;
        end
    end
    // ----------------------------------------
    // filter and pin gating
    // ----------------------------------------
    ctsw_filter #(.TAPS(`CTSW_FILT_TAPS)) u_filt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample(samp_tick),
        .din(capture_pin),
        .dout(filt_out)
    );
    // filter switch selects path instantly, so late switches expose edges
    wire path = noise_filter_enable ? filt_out : capture_pin;
    wire cap_sig = capture_pin_function & path;
    // ----------------------------------------
    // early filter window
    // ----------------------------------------
    reg func_d;
    reg [2:0] filt_cnt;
    // filter samples seen since the filter was switched on
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            func_d <= 1'b0;
            filt_cnt <= 3'h0;
        end else begin
            func_d <= capture_pin_function;
            if (!noise_filter_enable)
                filt_cnt <= 3'h0;
            else if (samp_tick && (filt_cnt < `CTSW_FILT_TAPS))
                filt_cnt <= filt_cnt + 3'h1;
        end
    end
    // function set early with a low level still reports a falling edge
    wire early_filt = noise_filter_enable & (filt_cnt < `CTSW_FILT_TAPS);
    wire phantom_fall = capture_pin_function & ~func_d & early_filt & ~cap_sig;
    wire rise = cap_sig & ~cap_d;
    wire fall = (~cap_sig & cap_d) | phantom_fall;
    wire sel_edge = timer_mode_register[`CTSW_MODE_IEDGE] ? rise : fall;
    wire [1:0] cclr = {timer_mode_register[`CTSW_MODE_CCLR_HI],
                       timer_mode_register[`CTSW_MODE_CCLR_LO]};
    wire clr = (cclr[0] & fall) | (cclr[1] & rise);
    wire ovf = count_tick & (capture_counter == 8'hFF) & ~clr;
    wire ovie = timer_mode_register[`CTSW_MODE_OVIE];
    wire rd_stat = rd_stb & (addr == `CTSW_ADDR_STAT);
    wire [3:0] ev = {ovf & ovie, fall, rise, sel_edge | (ovf & ovie)};
    // ----------------------------------------
    // counter, capture, registers
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_d <= 1'b0;
            capture_counter <= `CTSW_RST_BYTE;
            cap_rise <= `CTSW_RST_BYTE;
            cap_fall <= `CTSW_RST_BYTE;
            timer_mode_register <= `CTSW_RST_BYTE;
            capture_pin_function <= 1'b0;
            noise_filter_enable <= 1'b0;
            stat <= `CTSW_RST_NIB;
            mask <= `CTSW_RST_NIB;
            rdata <= `CTSW_RST_BYTE;
            capture_in_level <= 1'b0;
            irq <= 1'b0;
        end else begin
            cap_d <= cap_sig;
            capture_in_level <= cap_sig;
            if (clr)
                capture_counter <= 8'h00;
            else if (count_tick)
                capture_counter <= capture_counter + 8'h01;
            if (rise)
                cap_rise <= capture_counter;
            if (fall)
                cap_fall <= capture_counter;
            if (ovf) begin
                if (cap_sig)
                    timer_mode_register[`CTSW_MODE_OVFH] <= 1'b1;
                else
                    timer_mode_register[`CTSW_MODE_OVFL] <= 1'b1;
            end
            if (wr_stb) begin
                case (addr)
                    `CTSW_ADDR_MODE: begin
                        timer_mode_register[5:0] <= wdata[5:0];
                        if (!wdata[`CTSW_MODE_OVFH] && !(ovf && cap_sig))
                            timer_mode_register[`CTSW_MODE_OVFH] <= 1'b0;
                        if (!wdata[`CTSW_MODE_OVFL] && !(ovf && !cap_sig))
                            timer_mode_register[`CTSW_MODE_OVFL] <= 1'b0;
                    end
                    `CTSW_ADDR_PORT: begin
                        capture_pin_function <= wdata[`CTSW_PORT_FUNC];
                        noise_filter_enable <= wdata[`CTSW_PORT_NCS];
                    end
                    `CTSW_ADDR_MASK: mask <= wdata[3:0];
                    default: ;
                endcase
            end
            // set wins over read clear
            stat <= (rd_stat ? 4'h0 : stat) | ev;
            irq <= |(((rd_stat ? 4'h0 : stat) | ev) & mask);
            rdata <= 8'h00;
            if (rd_stb) begin
                case (addr)
                    `CTSW_ADDR_MODE: rdata <= timer_mode_register;
                    `CTSW_ADDR_PORT: rdata <= {6'h00, noise_filter_enable,
                                               capture_pin_function};
                    `CTSW_ADDR_COUNT: rdata <= capture_counter;
                    `CTSW_ADDR_CAPR: rdata <= cap_rise;
                    `CTSW_ADDR_CAPF: rdata <= cap_fall;
                    `CTSW_ADDR_STAT: rdata <= {4'h0, stat};
                    `CTSW_ADDR_MASK: rdata <= {4'h0, mask};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ==== bench/ctsw_core_chk.sv ====
`timescale 1ns/1ps
module ctsw_core_chk (
    input wire ref_clk,
    input wire rst_b,
    input wire watch_clk_in,
    input wire capture_pin,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] rdata,
    input wire capture_in_level,
    input wire irq
);
    // ----
    // shadow of port and mask writes
    // ----
    reg [1:0] port_q;
    reg [3:0] mask_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_q <= 2'h0;
            mask_q <= 4'h0;
        end else if (wr_stb && addr == 4'h1) begin
            port_q <= wdata[1:0];
        end else if (wr_stb && addr == 4'h6) begin
            mask_q <= wdata[3:0];
        end
    end
    a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
        else $error("rdata not zero outside read");
    a_unmapped_zero: assert property ($past(rd_stb) && $past(addr) > 4'h6 |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_port_readback: assert property ($past(rd_stb) && $past(addr) == 4'h1 |-> rdata[1:0] == port_q)
        else $error("port readback wrong");
    a_mask_readback: assert property ($past(rd_stb) && $past(addr) == 4'h6 |-> rdata[3:0] == mask_q)
        else $error("mask readback wrong");
    a_func_off_low: assert property (!port_q[0] [*3] |-> !capture_in_level)
        else $error("capture level high with function off");
    a_pin_follow: assert property ((port_q == 2'h1) [*3] |-> capture_in_level == $past(capture_pin))
        else $error("capture level not following pin");
    a_rise_needs_func: assert property ($rose(capture_in_level) |-> $past(port_q[0]))
        else $error("capture rise with function off");
    a_mask_quiet: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
        else $error("irq with all masked");
    c_irq: cover property ($rose(irq));
    c_fall: cover property ($fell(capture_in_level));
    c_read: cover property ($past(rd_stb) && rdata != 8'h00);
endmodule
bind ctsw_core ctsw_core_chk i_chk (.ref_clk, .rst_b, .watch_clk_in, .capture_pin, .addr,
    .wdata, .wr_stb, .rd_stb, .rdata, .capture_in_level, .irq);

// ==== bench/ctsw_pulse_src.sv ====
`timescale 1ns/1ps
module ctsw_pulse_src (
    input wire ref_clk,
    input wire level_req,
    output reg capture_pin
);
    initial capture_pin = 1'b0;
    always @(posedge ref_clk) begin
        capture_pin <= level_req;
    end
endmodule

// ==== bench/tb_capture_timer_switch_effects.sv ====
`timescale 1ns/1ps
module tb_capture_timer_switch_effects;
    reg ref_clk, rst_b, watch_clk_in, level_req, wr_stb, rd_stb;
    reg [3:0] addr;
    reg [7:0] wdata, v, c;
    wire capture_pin, capture_in_level, irq;
    wire [7:0] rdata;
    integer err_count = 0, checks = 0, cyc = 0, i;
    ctsw_pulse_src i_src (.ref_clk, .level_req, .capture_pin);
    ctsw_core i_dut (.ref_clk, .rst_b, .watch_clk_in, .capture_pin, .addr, .wdata, .wr_stb,
        .rd_stb, .rdata, .capture_in_level, .irq);
    // ----
    // bus and stimulus tasks
    // ----
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task wr(input [3:0] a, input [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        tick(1);
        wr_stb <= 1'b0;
        tick(1);
    endtask
    task rd(input [3:0] a, output [7:0] d);
        addr <= a;
        rd_stb <= 1'b1;
        tick(1);
        rd_stb <= 1'b0;
        #1 d = rdata;
        tick(1);
    endtask
    task lvl(input x);
        level_req <= x;
        tick(3);
    endtask
    task wclk(input integer n);
        repeat (n) begin
            watch_clk_in <= 1'b1;
            tick(3);
            watch_clk_in <= 1'b0;
            tick(3);
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            final_report;
        end
    end
    // ----
    // test sequence
    // ----
    initial begin
        rst_b = 1'b0;
        watch_clk_in = 1'b0;
        level_req = 1'b0;
        {wr_stb, rd_stb, addr, wdata} = 14'h0000;
        tick(3);
        rst_b <= 1'b1;
        tick(3);
        for (i = 0; i < 16; i = i + 1) begin
            rd(i[3:0], v);
            if (i != 2)
                chk("reset value", v, 8'h00);
        end
        $display("done reset");
        wr(4'h0, 8'h10);
        wr(4'h6, 8'h01);
        lvl(1'b1);
        wr(4'h1, 8'h01);
        tick(3);
        chk("level on", capture_in_level, 8'h01);
        chk("irq on", irq, 8'h01);
        rd(4'h5, v);
        chk("stat rise", v & 8'h07, 8'h03);
        tick(2);
        chk("irq clear", irq, 8'h00);
        wr(4'h1, 8'h00);
        tick(3);
        chk("level off", capture_in_level, 8'h00);
        chk("irq opposite", irq, 8'h00);
        rd(4'h5, v);
        chk("stat fall", v & 8'h07, 8'h04);
        wr(4'h1, 8'h02);
        wr(4'h1, 8'h03);
        tick(3);
        rd(4'h5, v);
        chk("stat filt rise", v & 8'h07, 8'h03);
        wr(4'h1, 8'h00);
        $display("done function switch");
        wr(4'h0, 8'h03);
        rd(4'h2, c);
        i = 0;
        do begin
            wclk(1);
            rd(4'h2, v);
            i = i + 1;
        end while (v === c && i < 8);
        wclk(4);
        rd(4'h2, c);
        chk("watch count", c, v + 8'h01);
        wclk(2);
        wr(4'h0, 8'h00);
        rd(4'h2, c);
        i = 0;
        do begin
            rd(4'h2, v);
            i = i + 1;
        end while (v === c && i < 40);
        wr(4'h0, 8'h03);
        rd(4'h2, c);
        chk("low to high", c, v);
        wr(4'h0, 8'h00);
        rd(4'h2, c);
        chk("high to low", c, v + 8'h01);
        $display("done clock switch");
        wr(4'h0, 8'h02);
        wr(4'h1, 8'h03);
        lvl(1'b0);
        tick(20);
        rd(4'h5, v);
        lvl(1'b1);
        lvl(1'b0);
        tick(20);
        chk("glitch", capture_in_level, 8'h00);
        lvl(1'b1);
        tick(20);
        chk("filtered high", capture_in_level, 8'h01);
        rd(4'h5, v);
        wr(4'h1, 8'h02);
        tick(3);
        chk("late clear", capture_in_level, 8'h00);
        rd(4'h5, v);
        chk("stat late", v & 8'h07, 8'h05);
        $display("done filter");
        wr(4'h6, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h1E);
        wr(4'h1, 8'h01);
        tick(2);
        chk("irq masked", irq, 8'h00);
        rd(4'h5, v);
        chk("stat masked", v & 8'h07, 8'h03);
        wr(4'h6, 8'h01);
        lvl(1'b0);
        tick(14);
        lvl(1'b1);
        tick(20);
        chk("irq pulse", irq, 8'h01);
        lvl(1'b0);
        rd(4'h3, v);
        chk("low width", v, 8'h08);
        rd(4'h4, v);
        chk("high width", v, 8'h0B);
        wr(4'h1, 8'h00);
        rd(4'h5, v);
        wr(4'h1, 8'h02);
        wr(4'h1, 8'h03);
        tick(2);
        rd(4'h5, v);
        chk("stat early low", v & 8'h07, 8'h04);
        $display("done pulse width");
        final_report;
    end
endmodule
